// ---- logic/escd_cmd_decoder.v ----
// Operation
// [R1] Decode command unit codes, including load addresses
// [R2] Dump counters on 101; dump and clear on 111
// [R3] Decode all eight receive unit codes (here only codes 1, 2 and 4 to 7 act; 0 and reserved 3 do nothing)
// [R4] Reset port register resets the block
// [R5] General pointer supplies addresses for start, base
// [R6] Registers give access to eeprom, flash, phy
// [R7] Command unit walks linked action command list
// [R8] Transmit accepts simplified or flexible layout
// [R9] Receive area built from host descriptors
// [R10] Simplified, flexible and header frame descriptors
// [R11] States change only by commands; status reports (here the walk end and the out-of-descriptor event also change them)
// [R12] Accepted nonzero command field clears to zero
// [R13] Reserved codes ignored, states unchanged
//
// Command decoder and control/status registers of the controller.
// Assumes a single-cycle register port master on the same clock.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "escd_defines.vh"

module escd_cmd_decoder #(
  parameter AW = 32
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Memory link port for the command list walk
  output reg [AW-1:0] list_addr,
  input wire [AW-1:0] list_link,
  input wire list_last,
  // Receive engine events
  input wire rx_frame_done,
  input wire rx_out_of_desc,
  // Serial access pins of eeprom, flash and phy management
  output reg eeprom_out,
  output reg flash_out,
  output reg phy_mgmt_out,
  // Statistics dump request to the DMA engine
  output reg dump_req,
  output reg dump_clear
);

  localparam CU_IDLE = 2'h0;
  localparam CU_SUSP = 2'h1;
  localparam CU_ACTIVE = 2'h2;

  reg [2:0] cu_cmd;
  reg [2:0] ru_cmd;
  reg [1:0] cu_state;
  reg [1:0] ru_state;
  reg [31:0] gen_ptr;
  reg [31:0] cu_base;
  reg [31:0] ru_base;
  reg [31:0] dump_addr;
  reg [31:0] hdr_size;
  reg [31:0] eeprom_reg;
  reg [31:0] flash_reg;
  reg [31:0] phy_mgmt_reg;
  reg tx_flex;
  reg [1:0] rfd_kind;
  reg [15:0] stat_cnt;
  reg soft_reset;
  reg sel_reset;
  reg ru_rbd_ok;
  reg [1:0] rx_frame_sync;
  reg [1:0] rx_norsc_sync;
  reg rx_frame_seen;
  reg [7:0] event_cnt;
  reg walk_start;
  reg walk_stop;
  reg [31:0] next_rdata;

  wire walk_busy;
  wire walk_done;
  wire [AW-1:0] walk_ptr;
  wire block_resetn;
  wire wr_cmd;
  wire frame_pulse;

  function [31:0] base_plus;
    input [31:0] base;
    input [31:0] ptr;
    begin
      base_plus = base + ptr;
    end
  endfunction

  // The reset port acts one cycle after its write, on the whole block
  assign block_resetn = resetn & ~soft_reset; // see [R4]
  assign wr_cmd = reg_wr && (reg_addr == `ESCD_OFF_CMD);
  assign frame_pulse = rx_frame_sync[1] & ~rx_frame_seen;

  escd_list_walker #(
    .AW(AW)
  ) u_walker (
    .clk(clk),
    .resetn(block_resetn),
    .start(walk_start),
    .stop(walk_stop),
    .head(base_plus(cu_base, gen_ptr)),
    .fetch_addr(),
    .fetch_link(list_link),
    .fetch_last(list_last),
    .busy(walk_busy),
    .cur_ptr(walk_ptr),
    .done(walk_done)
  );

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      soft_reset <= 1'b0;
    else
      soft_reset <= reg_wr && (reg_addr == `ESCD_OFF_RESET_PORT) &&
        (reg_wdata == `ESCD_RESET_KEY); // see [R4]
  end

  // Receive events come from another clock domain
  always @(posedge clk or negedge block_resetn)
  begin
    if (!block_resetn)
    begin
      rx_frame_sync <= 2'h0;
      rx_norsc_sync <= 2'h0;
      rx_frame_seen <= 1'b0;
    end
    else
    begin
      rx_frame_sync <= {rx_frame_sync[0], rx_frame_done};
      rx_norsc_sync <= {rx_norsc_sync[0], rx_out_of_desc};
      rx_frame_seen <= rx_frame_sync[1];
    end
  end

  always @(posedge clk or negedge block_resetn)
  begin
    if (!block_resetn)
    begin
      cu_cmd <= 3'h0;
      ru_cmd <= 3'h0;
      cu_state <= CU_IDLE;
      ru_state <= `ESCD_ST_IDLE;
      gen_ptr <= 32'h0000_0000;
      cu_base <= 32'h0000_0000;
      ru_base <= 32'h0000_0000;
      dump_addr <= 32'h0000_0000;
      hdr_size <= `ESCD_HDR_SIZE_RST;
      eeprom_reg <= 32'h0000_0000;
      flash_reg <= 32'h0000_0000;
      phy_mgmt_reg <= 32'h0000_0000;
      tx_flex <= `ESCD_TX_SIMPLE;
      rfd_kind <= `ESCD_RFD_SIMPLE;
      stat_cnt <= 16'h0000;
      sel_reset <= 1'b0;
      ru_rbd_ok <= 1'b1;
      event_cnt <= 8'h00;
      walk_start <= 1'b0;
      walk_stop <= 1'b0;
      dump_req <= 1'b0;
      dump_clear <= 1'b0;
    end
    else
    begin
      walk_start <= 1'b0;
      walk_stop <= 1'b0;
      dump_req <= 1'b0;
      dump_clear <= 1'b0;
      sel_reset <= reg_wr && (reg_addr == `ESCD_OFF_RESET_PORT) &&
        (reg_wdata == `ESCD_SEL_RESET_KEY);
      if (sel_reset)
      begin
        cu_state <= CU_IDLE;
        ru_state <= `ESCD_ST_IDLE;
        walk_stop <= 1'b1;
      end
      if (reg_wr)
      begin
        case (reg_addr)
          `ESCD_OFF_CMD:
          begin
            cu_cmd <= reg_wdata[`ESCD_CUC_LSB+2:`ESCD_CUC_LSB];
            ru_cmd <= reg_wdata[`ESCD_RUC_LSB+2:`ESCD_RUC_LSB];
          end
          `ESCD_OFF_GEN_PTR: gen_ptr <= reg_wdata; // see [R5]
          `ESCD_OFF_EEPROM: eeprom_reg <= reg_wdata; // see [R6]
          `ESCD_OFF_FLASH: flash_reg <= reg_wdata; // see [R6]
          `ESCD_OFF_PHY_MGMT: phy_mgmt_reg <= reg_wdata; // see [R6]
          `ESCD_OFF_MODES:
          begin
            tx_flex <= reg_wdata[0]; // see [R8]
            rfd_kind <= reg_wdata[5:4]; // see [R10]
          end
          default: ;
        endcase
      end
      // Command unit: decode then clear the field to signal acceptance
      if (!wr_cmd && cu_cmd != `ESCD_CU_NOP)
      begin
        cu_cmd <= 3'h0; // see [R12]
        case (cu_cmd) // see [R1]
          `ESCD_CU_START:
          begin
            cu_state <= CU_ACTIVE; // see [R11]
            walk_start <= 1'b1; // see [R7]
          end
          `ESCD_CU_RESUME:
            if (cu_state == CU_SUSP)
              cu_state <= CU_ACTIVE;
          `ESCD_CU_LOAD_DUMP: dump_addr <= gen_ptr; // see [R5]
          `ESCD_CU_LOAD_BASE: cu_base <= gen_ptr; // see [R5]
          `ESCD_CU_DUMP: dump_req <= 1'b1; // see [R2]
          `ESCD_CU_DUMP_RESET:
          begin
            dump_req <= 1'b1; // see [R2]
            dump_clear <= 1'b1;
          end
          default: ; // see [R13]
        endcase
      end
      else if (walk_done)
        cu_state <= CU_IDLE;
      // Receive unit
      if (!wr_cmd && ru_cmd != `ESCD_RU_NOP)
      begin
        ru_cmd <= 3'h0; // see [R12]
        case (ru_cmd) // see [R3]
          `ESCD_RU_START:
          begin
            ru_state <= `ESCD_ST_ACTIVE; // see [R9]
            ru_rbd_ok <= 1'b1;
          end
          `ESCD_RU_RESUME:
            if (ru_state == `ESCD_ST_SUSP)
              ru_state <= `ESCD_ST_ACTIVE;
          `ESCD_RU_ABORT: ru_state <= `ESCD_ST_IDLE;
          `ESCD_RU_LOAD_HDR: hdr_size <= gen_ptr;
          `ESCD_RU_LOAD_BASE: ru_base <= gen_ptr; // see [R5]
          `ESCD_RU_BD_RESUME:
          begin
            ru_rbd_ok <= 1'b1;
            if (ru_state == `ESCD_ST_NORES)
              ru_state <= `ESCD_ST_ACTIVE;
          end
          default: ; // see [R13]
        endcase
      end
      else if (rx_norsc_sync[1] && ru_state == `ESCD_ST_ACTIVE)
      begin
        ru_state <= `ESCD_ST_NORES; // see [R9]
        ru_rbd_ok <= 1'b0;
      end
      // Counters clear after their dump is issued
      if (dump_clear)
        stat_cnt <= 16'h0000; // see [R2]
      else if (frame_pulse && ru_state == `ESCD_ST_ACTIVE)
        stat_cnt <= stat_cnt + 16'h0001;
      if (frame_pulse || walk_done)
        event_cnt <= event_cnt + 8'h01;
    end
  end

  always @*
  begin
    case (reg_addr)
      `ESCD_OFF_CMD:
        next_rdata = {21'h0, cu_cmd, 5'h0, ru_cmd};
      `ESCD_OFF_STATUS:
        next_rdata = {23'h0, ru_rbd_ok, 2'h0, cu_state, 2'h0, ru_state}; // see [R11]
      `ESCD_OFF_GEN_PTR: next_rdata = gen_ptr;
      `ESCD_OFF_EEPROM: next_rdata = eeprom_reg;
      `ESCD_OFF_FLASH: next_rdata = flash_reg;
      `ESCD_OFF_PHY_MGMT: next_rdata = phy_mgmt_reg;
      `ESCD_OFF_CU_BASE: next_rdata = cu_base;
      `ESCD_OFF_RU_BASE: next_rdata = ru_base;
      `ESCD_OFF_DUMP_ADDR: next_rdata = dump_addr;
      `ESCD_OFF_HDR_SIZE: next_rdata = hdr_size;
      `ESCD_OFF_MODES: next_rdata = {26'h0, rfd_kind, 3'h0, tx_flex};
      `ESCD_OFF_STAT_CNT: next_rdata = {16'h0, stat_cnt};
      `ESCD_OFF_LIST_PTR: next_rdata = walk_ptr[31:0];
      `ESCD_OFF_EVENTS: next_rdata = {24'h0, event_cnt};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge block_resetn)
  begin
    if (!block_resetn)
    begin
      reg_rdata <= 32'h0000_0000;
      list_addr <= {AW{1'b0}};
      eeprom_out <= 1'b0;
      flash_out <= 1'b0;
      phy_mgmt_out <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      // Mirrors the walker's current pointer, so the memory answers for the
      // block being stepped in the same cycle rather than one block late
      if (walk_stop)
        list_addr <= {AW{1'b0}};
      else if (walk_start)
        list_addr <= base_plus(cu_base, gen_ptr); // see [R7]
      else if (walk_busy)
        list_addr <= list_last ? {AW{1'b0}} : list_link; // see [R7]
      eeprom_out <= eeprom_reg[0]; // see [R6]
      flash_out <= flash_reg[0];
      phy_mgmt_out <= phy_mgmt_reg[0];
    end
  end

endmodule

// ---- logic/escd_defines.vh ----
// Register map, field positions, command codes and reset values of the
// command decoder. Included by every design file; holds definitions only.
`ifndef ESCD_DEFINES_VH
`define ESCD_DEFINES_VH

// Register byte offsets (word aligned)
`define ESCD_OFF_CMD 8'h00
`define ESCD_OFF_STATUS 8'h04
`define ESCD_OFF_GEN_PTR 8'h08
`define ESCD_OFF_RESET_PORT 8'h0c
`define ESCD_OFF_EEPROM 8'h10
`define ESCD_OFF_FLASH 8'h14
`define ESCD_OFF_PHY_MGMT 8'h18
`define ESCD_OFF_CU_BASE 8'h1c
`define ESCD_OFF_RU_BASE 8'h20
`define ESCD_OFF_DUMP_ADDR 8'h24
`define ESCD_OFF_HDR_SIZE 8'h28
`define ESCD_OFF_MODES 8'h2c
`define ESCD_OFF_STAT_CNT 8'h30
`define ESCD_OFF_LIST_PTR 8'h34
`define ESCD_OFF_EVENTS 8'h38

// Command word fields
`define ESCD_CUC_LSB 8
`define ESCD_RUC_LSB 0

// Command unit codes
`define ESCD_CU_NOP 3'h0
`define ESCD_CU_START 3'h1
`define ESCD_CU_RESUME 3'h2
`define ESCD_CU_RSVD 3'h3
`define ESCD_CU_LOAD_DUMP 3'h4
`define ESCD_CU_DUMP 3'h5
`define ESCD_CU_LOAD_BASE 3'h6
`define ESCD_CU_DUMP_RESET 3'h7

// Receive unit codes
`define ESCD_RU_NOP 3'h0
`define ESCD_RU_START 3'h1
`define ESCD_RU_RESUME 3'h2
`define ESCD_RU_RSVD 3'h3
`define ESCD_RU_ABORT 3'h4
`define ESCD_RU_LOAD_HDR 3'h5
`define ESCD_RU_LOAD_BASE 3'h6
`define ESCD_RU_BD_RESUME 3'h7

// Unit states reported in the status word
`define ESCD_ST_IDLE 2'h0
`define ESCD_ST_SUSP 2'h1
`define ESCD_ST_ACTIVE 2'h2
`define ESCD_ST_NORES 2'h3

// Reset port: the first value resets the whole block, the second only returns the unit states to idle and stops the list walk
`define ESCD_RESET_KEY 32'h0000_0000
`define ESCD_SEL_RESET_KEY 32'h0000_0002

// Transmit and receive descriptor kinds
`define ESCD_TX_SIMPLE 1'b0
`define ESCD_TX_FLEX 1'b1
`define ESCD_RFD_SIMPLE 2'h0
`define ESCD_RFD_FLEX 2'h1
`define ESCD_RFD_HEADER 2'h2

// Reset values and step cycle count
`define ESCD_HDR_SIZE_RST 32'h0000_0000
`define ESCD_STEP_CYCLES 4
`endif

// ---- logic/escd_list_walker.v ----
// List walker: steps along a linked list of host memory blocks,
// one link per step. Assumes the memory port answers in the same cycle.
`timescale 1ns/1ps
`include "escd_defines.vh"

module escd_list_walker #(
  parameter AW = 32
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control
  input wire start,
  input wire stop,
  input wire [AW-1:0] head,
  // Link fetch port
  output wire [AW-1:0] fetch_addr,
  input wire [AW-1:0] fetch_link,
  input wire fetch_last,
  // State
  output reg busy,
  output reg [AW-1:0] cur_ptr,
  output reg done
);

  assign fetch_addr = cur_ptr;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      cur_ptr <= {AW{1'b0}};
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (stop)
        busy <= 1'b0;
      else if (start)
      begin
        busy <= 1'b1;
        cur_ptr <= head;
      end
      else if (busy)
      begin
        // Each block names the next; the last one ends the walk
        if (fetch_last)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cur_ptr <= fetch_link;
      end
    end
  end

endmodule

// ---- tb/escd_checker.sv ----
// Port assertions of the command decoder.
// Assumes it is bound to the decoder and shares its clock and reset.
`timescale 1ns/1ps
`include "escd_defines.vh"
module escd_checker #(
  parameter AW = 32
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Link port and events
  input wire [AW-1:0] list_addr,
  input wire [AW-1:0] list_link,
  input wire list_last,
  input wire rx_frame_done,
  input wire rx_out_of_desc,
  // Outputs
  input wire eeprom_out,
  input wire flash_out,
  input wire phy_mgmt_out,
  input wire dump_req,
  input wire dump_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire wr_cmd = reg_wr && reg_addr == `ESCD_OFF_CMD;
  wire [2:0] cu = reg_wdata[10:8];
  reg [3:0] dump_hist;
  // Remembers dump commands so a pulse can be traced back to its cause
  always @(posedge clk or negedge resetn)
    if (!resetn)
      dump_hist <= 4'h0;
    else
      dump_hist <= {dump_hist[2:0], wr_cmd && cu[2] && cu[0]};
  a_read_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (reg_rd && (reg_addr > `ESCD_OFF_EVENTS
    || reg_addr[1:0] != 2'h0) |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_dump_plain: assert property (wr_cmd && cu == `ESCD_CU_DUMP
    |-> ##[1:4] dump_req && !dump_clear) else $error("dump not requested");
  a_dump_clear: assert property (wr_cmd && cu == `ESCD_CU_DUMP_RESET
    |-> ##[1:4] dump_req && dump_clear) else $error("dump and clear not requested");
  a_clear_pair: assert property (dump_clear |-> dump_req)
    else $error("clear without dump");
  a_dump_cause: assert property (dump_req |-> dump_hist != 4'h0)
    else $error("dump without command");
  // The pin follows its register one cycle after the register took the write
  a_eeprom_pin: assert property (reg_wr && reg_addr == `ESCD_OFF_EEPROM
    |-> ##2 eeprom_out == $past(reg_wdata[0], 2)) else $error("eeprom pin wrong");
  a_flash_pin: assert property (reg_wr && reg_addr == `ESCD_OFF_FLASH
    |-> ##2 flash_out == $past(reg_wdata[0], 2)) else $error("flash pin wrong");
  a_phy_pin: assert property (reg_wr && reg_addr == `ESCD_OFF_PHY_MGMT
    |-> ##2 phy_mgmt_out == $past(reg_wdata[0], 2)) else $error("phy pin wrong");
  c_dump_clear: cover property (dump_req && dump_clear);
  c_walk: cover property (list_addr != 32'h0);
  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind escd_cmd_decoder escd_checker #(.AW(AW)) u_chk (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .list_addr(list_addr), .list_link(list_link),
  .list_last(list_last), .rx_frame_done(rx_frame_done), .rx_out_of_desc(rx_out_of_desc),
  .eeprom_out(eeprom_out), .flash_out(flash_out), .phy_mgmt_out(phy_mgmt_out),
  .dump_req(dump_req), .dump_clear(dump_clear));

// ---- tb/escd_mem_model.sv ----
// Host memory holding a command list with blocks 16 bytes apart.
// Assumes the decoder expects the link in the same cycle as the address.
`timescale 1ns/1ps
module escd_mem_model #(
  parameter LAST = 32'h0000_1120
)(
  // Clock
  input wire clk,
  // Link port
  input wire [31:0] list_addr,
  output reg [31:0] list_link,
  output reg list_last
);
  reg [31:0] noise = 32'h5a5a_a5a5;
  always @(posedge clk)
    noise <= ~noise;
  // Outside a walk the port shows a changing pattern, never a stale link
  always @*
  begin
    list_link = list_addr + 32'h10;
    list_last = list_addr == LAST;
    if (list_addr == 32'h0)
    begin
      list_link = noise;
      list_last = noise[0];
    end
  end
endmodule

// ---- tb/escd_cmd_decoder_test.sv ----
// Self-checking bench of the command decoder over its register port.
// Assumes the list memory model on the link port.
`timescale 1ns/1ps
`include "escd_defines.vh"
module escd_cmd_decoder_test;
  reg clk, resetn, reg_wr, reg_rd, rx_frame_done, rx_out_of_desc;
  reg [7:0] reg_addr, a;
  reg [31:0] reg_wdata;
  wire [31:0] reg_rdata, list_addr, list_link;
  wire list_last, eeprom_out, flash_out, phy_mgmt_out, dump_req, dump_clear;
  integer bad_count = 0;
  integer tests_run = 0;
  integer i;
  localparam [31:0] ALL = 32'hffff_ffff;
  escd_cmd_decoder #(.AW(32)) u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .list_addr(list_addr), .list_link(list_link), .list_last(list_last),
    .rx_frame_done(rx_frame_done), .rx_out_of_desc(rx_out_of_desc),
    .eeprom_out(eeprom_out), .flash_out(flash_out), .phy_mgmt_out(phy_mgmt_out),
    .dump_req(dump_req), .dump_clear(dump_clear));
  escd_mem_model u_mem (.clk(clk), .list_addr(list_addr), .list_link(list_link),
    .list_last(list_last));
  task give_verdict;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        $display("FAIL %s expected %h seen %h", n, e, g);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [31:0] e, input [31:0] m, input string n);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata & m);
    end
  endtask
  // Loads go through the general pointer; the field must read back cleared
  task ld(input [31:0] c, input [7:0] ad, input [31:0] v);
    begin
      wr(`ESCD_OFF_GEN_PTR, v);
      wr(`ESCD_OFF_CMD, c);
      rd(`ESCD_OFF_CMD, 32'h0, ALL, "cmd_field");
      rd(ad, v, ALL, "loaded_reg");
    end
  endtask
  function [31:0] pick(input integer s);
    pick = s ? list_addr : {31'h0, dump_req};
  endfunction
  task wfor(input integer s, input [31:0] e);
    integer k;
    begin
      #1 k = 0;
      while (pick(s) !== e && k < 16)
      begin
        @(posedge clk);
        #1 k = k + 1;
      end
      chk("wait_value", e, pick(s));
      // A wait that ran out has been counted; stop the run there
      if (pick(s) !== e)
        give_verdict;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_frame_done = 1'b0;
    rx_out_of_desc = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(`ESCD_OFF_GEN_PTR, 32'h0, ALL, "gen_ptr_reset");
    rd(8'h3c, 32'h0, ALL, "unmapped");
    a = `ESCD_OFF_EEPROM;
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(a, 32'h1);
      rd(a, 32'h1, ALL, "serial_reg");
      a = a + 8'h04;
    end
    #1 chk("serial_pins", 32'h7, {29'h0, phy_mgmt_out, flash_out, eeprom_out});
    ld(32'h600, `ESCD_OFF_CU_BASE, 32'h1000);
    ld(32'h400, `ESCD_OFF_DUMP_ADDR, 32'h2340);
    ld(32'h6, `ESCD_OFF_RU_BASE, 32'h3450);
    ld(32'h5, `ESCD_OFF_HDR_SIZE, 32'h80);
    wr(`ESCD_OFF_CMD, 32'h500);
    wfor(0, 32'h1);
    chk("dump_clear", 32'h0, {31'h0, dump_clear});
    wr(`ESCD_OFF_CMD, 32'h700);
    wfor(0, 32'h1);
    chk("dump_clear", 32'h1, {31'h0, dump_clear});
    // Receive unit: start, reserved, abort, then resume from idle
    wr(`ESCD_OFF_CMD, 32'h1);
    rd(`ESCD_OFF_STATUS, 32'h2, 32'h3, "ru_state");
    wr(`ESCD_OFF_CMD, 32'h3);
    rd(`ESCD_OFF_STATUS, 32'h2, 32'h3, "ru_state");
    wr(`ESCD_OFF_CMD, 32'h4);
    rd(`ESCD_OFF_STATUS, 32'h0, 32'h3, "ru_state");
    wr(`ESCD_OFF_CMD, 32'h2);
    rd(`ESCD_OFF_STATUS, 32'h0, 32'h3, "ru_state");
    wr(`ESCD_OFF_CMD, 32'h7);
    rd(`ESCD_OFF_CMD, 32'h0, ALL, "cmd_field");
    // List walk starts at command base plus general pointer
    wr(`ESCD_OFF_GEN_PTR, 32'h100);
    wr(`ESCD_OFF_CMD, 32'h100);
    wfor(1, 32'h1100);
    wfor(1, 32'h1110);
    wfor(1, 32'h1120);
    rd(`ESCD_OFF_LIST_PTR, 32'h1120, ALL, "list_ptr");
    wr(`ESCD_OFF_CMD, 32'h300);
    rd(`ESCD_OFF_STATUS, 32'h0, 32'h30, "cu_state");
    wr(`ESCD_OFF_MODES, 32'h21);
    rd(`ESCD_OFF_MODES, 32'h21, ALL, "modes");
    wr(`ESCD_OFF_MODES, 32'h10);
    rd(`ESCD_OFF_MODES, 32'h10, ALL, "modes");
    // The statistics counter counts frames only while the receive unit is active
    wr(`ESCD_OFF_CMD, 32'h1);
    rx_frame_done <= 1'b1;
    repeat (4) @(posedge clk);
    rx_frame_done <= 1'b0;
    rx_out_of_desc <= 1'b1;
    repeat (4) @(posedge clk);
    rx_out_of_desc <= 1'b0;
    rd(`ESCD_OFF_STAT_CNT, 32'h1, ALL, "frame_count");
    rd(`ESCD_OFF_STATUS, 32'h3, 32'h103, "ru_no_res");
    wr(`ESCD_OFF_CMD, 32'h7);
    rd(`ESCD_OFF_STATUS, 32'h102, 32'h103, "ru_bd_resume");
    rd(`ESCD_OFF_EVENTS, 32'h2, ALL, "events");
    wr(`ESCD_OFF_CMD, 32'h1);
    wr(`ESCD_OFF_GEN_PTR, 32'h77);
    wr(`ESCD_OFF_RESET_PORT, 32'h2);
    repeat (2) @(posedge clk);
    rd(`ESCD_OFF_STATUS, 32'h0, 32'h33, "unit_states");
    rd(`ESCD_OFF_GEN_PTR, 32'h77, ALL, "gen_ptr_kept");
    wr(`ESCD_OFF_RESET_PORT, 32'h0);
    repeat (2) @(posedge clk);
    rd(`ESCD_OFF_GEN_PTR, 32'h0, ALL, "gen_ptr_reset");
    rd(`ESCD_OFF_CU_BASE, 32'h0, ALL, "cu_base_reset");
    give_verdict;
  end
endmodule
